// file: inc/bcdop_pkg.sv
// Summary of operation
// - After a request rising edge the value goes on the data lines and valid rises in the same cycle, 30 ms plus a few synchroniser cycles later.
// - In single output valid falls 40 ms after rising and the data lines clear 16 ms later.
// - While the request stays high a fresh value is presented every 64 ms.
// - A hold during a changeover yields the old or new value, never a low gap on the data lines.
package bcdop_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
	localparam int unsigned SETUP_MS      = 30;
	localparam int unsigned VALID_MS      = 40;
	localparam int unsigned RELEASE_MS    = 16;
	localparam int unsigned PERIOD_MS     = 64;
	localparam int unsigned SETUP_CYC     = SETUP_MS * CYC_PER_MS;
	localparam int unsigned VALID_CYC     = VALID_MS * CYC_PER_MS;
	localparam int unsigned RELEASE_CYC   = RELEASE_MS * CYC_PER_MS;
	localparam int unsigned PERIOD_CYC    = PERIOD_MS * CYC_PER_MS;
	localparam int          CNT_W         = 23;

	// ****************************************
	// Data path
	// ****************************************
	localparam int          DATA_W        = 24;
	localparam int          FIFO_DEPTH    = 8;
	localparam logic [DATA_W-1:0] DATA_IDLE = 24'h00_0000;

	typedef enum logic [2:0] {
		BCDOP_IDLE    = 3'b000,
		BCDOP_SETUP   = 3'b001,
		BCDOP_VALID   = 3'b010,
		BCDOP_RELEASE = 3'b011,
		BCDOP_CONT    = 3'b100
	} bcdop_state_t;

endpackage

// file: rtl/bcdop_port.sv
module bcdop_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,    // Clock
	input  wire logic             rst_i,    // Sync reset
	input  wire logic [WIDTH-1:0] s_data_i, // Write data
	input  wire logic             s_valid_i,// Write valid
	output logic                  s_ready_o,// Not full
	output logic      [WIDTH-1:0] m_data_o, // Head word
	output logic                  m_valid_o,// Not empty
	input  wire logic             m_ready_i // Pop
);
	localparam int AW = $clog2(DEPTH);

	// ****************************************
	// Pointers and level
	// ****************************************
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} bcdop_fifo_st_t;

	bcdop_fifo_st_t      st_ff;
	bcdop_fifo_st_t      nxt_st;
	logic [WIDTH-1:0]    mem_ff [DEPTH];
	logic                push;
	logic                pop;

	// ****************************************
	// Flags and head word
	// ****************************************
	assign s_ready_o = (st_ff.cnt != (AW+1)'(DEPTH));
	assign m_valid_o = (st_ff.cnt != '0);
	assign m_data_o  = mem_ff[st_ff.rp];
	assign push      = s_valid_i && s_ready_o;
	assign pop       = m_ready_i && m_valid_o;

	// ****************************************
	// Pointer and level update
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		if (push) begin
			nxt_st.wp = st_ff.wp + 1'b1;
		end
		if (pop) begin
			nxt_st.rp = st_ff.rp + 1'b1;
		end
		nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
		// Storage is not cleared; the level alone marks it empty
		if (rst_i) begin
			nxt_st = '0;
		end
	end

	// ****************************************
	// Registers and storage
	// ****************************************
	always_ff @(posedge clk_i) begin
		st_ff <= nxt_st;
		if (push) begin
			mem_ff[st_ff.wp] <= s_data_i;
		end
	end
endmodule

module bcdop_port
	import bcdop_pkg::*;
#(
	parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
) (
	input  wire logic              clk_i,        // 100 MHz clock
	input  wire logic              rst_i,        // Sync reset, high
	input  wire logic              request_i,    // Request pin from reader
	input  wire logic              hold_i,       // Hold pin, freezes value
	input  wire logic [DATA_W-1:0] meas_data_i,  // Measurement, BCD digits
	input  wire logic              meas_valid_i, // Measurement offered
	output logic                   meas_ready_o, // FIFO has room
	output logic      [DATA_W-1:0] bcd_data_o,   // BCD data lines
	output logic                   data_valid_o  // Data-qualified strobe
);
	// ****************************************
	// Interval lengths in clock cycles
	// ****************************************
	// Counts scale with CYC_PER_MS_P so a bench may shorten them
	localparam int unsigned SETUP_N   = SETUP_MS * CYC_PER_MS_P;
	localparam int unsigned VALID_N   = VALID_MS * CYC_PER_MS_P;
	localparam int unsigned RELEASE_N = RELEASE_MS * CYC_PER_MS_P;
	localparam int unsigned PERIOD_N  = PERIOD_MS * CYC_PER_MS_P;

	// ****************************************
	// State record
	// ****************************************
	typedef struct packed {
		logic [1:0]        req_sync;
		logic [1:0]        hold_sync;
		logic              req_prev;
		bcdop_state_t      state;
		logic [CNT_W-1:0]  cnt;
		logic [DATA_W-1:0] latest;
		logic [DATA_W-1:0] data;
		logic              valid;
	} bcdop_st_t;

	bcdop_st_t         st_ff;
	bcdop_st_t         nxt_st;
	logic [DATA_W-1:0] head;
	logic              head_valid;
	logic              req;
	logic              hold;

	// ****************************************
	// Measurement buffer
	// ****************************************
	bcdop_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.s_data_i  (meas_data_i),
		.s_valid_i (meas_valid_i),
		.s_ready_o (meas_ready_o),
		.m_data_o  (head),
		.m_valid_o (head_valid),
		.m_ready_i (!hold)
	);

	// ****************************************
	// Synchronised pins and outputs
	// ****************************************
	assign req          = st_ff.req_sync[1];
	assign hold         = st_ff.hold_sync[1];
	assign bcd_data_o   = st_ff.data;
	assign data_valid_o = st_ff.valid;

	always_comb begin
		// ****************************************
		// Synchronisers, edge memory, free counter
		// ****************************************
		nxt_st           = st_ff;
		nxt_st.req_sync  = {st_ff.req_sync[0], request_i};
		nxt_st.hold_sync = {st_ff.hold_sync[0], hold_i};
		nxt_st.req_prev  = req;
		nxt_st.cnt       = st_ff.cnt + 1'b1;
		// ****************************************
		// Latest value; frozen while hold is active
		// ****************************************
		if (head_valid && !hold) begin
			nxt_st.latest = head;
		end

		// ****************************************
		// Output sequencer
		// ****************************************
		unique case (st_ff.state)
			BCDOP_IDLE: begin
				nxt_st.cnt   = '0;
				nxt_st.data  = DATA_IDLE;
				nxt_st.valid = 1'b0;
				if (req && !st_ff.req_prev) begin
					nxt_st.state = BCDOP_SETUP;
				end
			end
			BCDOP_SETUP: begin
				if (st_ff.cnt == CNT_W'(SETUP_N - 1)) begin
					nxt_st.data  = st_ff.latest;
					nxt_st.valid = 1'b1;
					nxt_st.cnt   = '0;
					nxt_st.state = BCDOP_VALID;
				end
			end
			BCDOP_VALID: begin
				if (req) begin
					// Counter runs on so the first refresh is one period after the strobe
					nxt_st.state = BCDOP_CONT;
				end else if (st_ff.cnt == CNT_W'(VALID_N - 1)) begin
					nxt_st.valid = 1'b0;
					nxt_st.cnt   = '0;
					nxt_st.state = BCDOP_RELEASE;
				end
			end
			BCDOP_CONT: begin
				nxt_st.valid = 1'b1;
				if (!req) begin
					nxt_st.cnt   = '0;
					nxt_st.state = BCDOP_VALID;
				end else if (st_ff.cnt == CNT_W'(PERIOD_N - 1)) begin
					// Data swaps directly, no low gap
					nxt_st.data = st_ff.latest;
					nxt_st.cnt  = '0;
				end
			end
			BCDOP_RELEASE: begin
				if (st_ff.cnt == CNT_W'(RELEASE_N - 1)) begin
					nxt_st.data  = DATA_IDLE;
					nxt_st.state = BCDOP_IDLE;
				end
			end
			default: begin
				nxt_st.state = BCDOP_IDLE;
			end
		endcase

		// ****************************************
		// Synchronous reset
		// ****************************************
		if (rst_i) begin
			nxt_st       = '0;
			nxt_st.state = BCDOP_IDLE;
			nxt_st.data  = DATA_IDLE;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk_i) begin
		st_ff <= nxt_st;
	end
endmodule

// file: tb/bcdop_port_assertions.sv
module bcdop_port_assertions
	import bcdop_pkg::*;
#(
	parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
) (
	input wire logic              clk_i,        // Clock
	input wire logic              rst_i,        // Reset
	input wire logic              request_i,    // Request
	input wire logic [DATA_W-1:0] bcd_data_o,   // Data lines
	input wire logic              data_valid_o  // Strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned SETUP_N   = SETUP_MS * CYC_PER_MS_P;
	localparam int unsigned VALID_N   = VALID_MS * CYC_PER_MS_P;
	localparam int unsigned RELEASE_N = RELEASE_MS * CYC_PER_MS_P;
	localparam int unsigned PERIOD_N  = PERIOD_MS * CYC_PER_MS_P;
	logic        req_d_ff;
	logic [31:0] rcnt_ff;
	logic [31:0] vcnt_ff;
	logic [31:0] lcnt_ff;
	always_ff @(posedge clk_i) begin
		req_d_ff <= request_i;
		rcnt_ff  <= (rst_i || (request_i && !req_d_ff)) ? '0 : rcnt_ff + 1;
		vcnt_ff  <= (rst_i || !data_valid_o) ? '0 : vcnt_ff + 1;
		lcnt_ff  <= (rst_i || data_valid_o) ? '0 : lcnt_ff + 1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
		!data_valid_o && bcd_data_o == DATA_IDLE) else $error("outputs active after reset");
	a_setup_time: assert property ($rose(data_valid_o) |->
		rcnt_ff >= SETUP_N && rcnt_ff <= SETUP_N + 5) else $error("setup time wrong");
	a_strobe_width: assert property ($fell(data_valid_o) |->
		vcnt_ff >= VALID_N - 1) else $error("strobe too short");
	a_refresh_period: assert property (data_valid_o && $past(data_valid_o)
		&& $changed(bcd_data_o) |-> (vcnt_ff + 1) % PERIOD_N < 3) else $error("bad refresh");
	a_release_idle: assert property (!data_valid_o && lcnt_ff > RELEASE_N + 1
		|-> bcd_data_o == DATA_IDLE) else $error("data not released");
endmodule

bind bcdop_port bcdop_port_assertions #(.CYC_PER_MS_P(CYC_PER_MS_P)) chk (.clk_i(clk_i),
	.rst_i(rst_i),
	.request_i(request_i), .bcd_data_o(bcd_data_o), .data_valid_o(data_valid_o));

// file: tb/bcdop_reader.sv
module bcdop_reader
	import bcdop_pkg::*;
(
	input  wire logic              clk_i,        // Clock
	input  wire logic              go_i,         // Wants a reading
	input  wire logic              data_valid_i, // Strobe
	input  wire logic [DATA_W-1:0] bcd_data_i,   // Data lines
	output logic                   request_o,    // Request pin
	output logic      [DATA_W-1:0] got_o         // Last value read
);
	timeunit 1ns;
	timeprecision 1ps;
	initial request_o = 1'b0;
	always @(negedge clk_i) request_o <= go_i;
	always @(posedge clk_i) if (data_valid_i) got_o <= bcd_data_i;
endmodule

// file: tb/bcd_result_output_port_test.sv
module bcd_result_output_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	import bcdop_pkg::*;
	localparam int unsigned TB_CPM    = 100;
	localparam int unsigned T_RELEASE = RELEASE_MS * TB_CPM;
	localparam int unsigned T_PERIOD  = PERIOD_MS * TB_CPM;
	localparam int unsigned T_GAP     = 20 * TB_CPM;
	localparam int unsigned T_LIMIT   = (VALID_MS + 10) * TB_CPM;
	logic              clk_i = 0, rst_i = 1, hold_i = 1, go = 0;
	logic              meas_valid_i = 0, meas_ready_o, request, data_valid_o;
	logic [DATA_W-1:0] meas_data_i = '0, bcd_data_o, got;
	int                err_count = 0, samples_checked = 0;
	always #5 clk_i = ~clk_i;
	bcdop_port #(.CYC_PER_MS_P(TB_CPM)) uut (.clk_i(clk_i), .rst_i(rst_i),
		.request_i(request), .hold_i(hold_i),
		.meas_data_i(meas_data_i), .meas_valid_i(meas_valid_i), .meas_ready_o(meas_ready_o),
		.bcd_data_o(bcd_data_o), .data_valid_o(data_valid_o));
	bcdop_reader rdr (.clk_i(clk_i), .go_i(go), .data_valid_i(data_valid_o),
		.bcd_data_i(bcd_data_o), .request_o(request), .got_o(got));
	task chk(input logic [DATA_W-1:0] a, e);
		samples_checked++;
		if (a !== e) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, a, e);
		end
	endtask
	task wait_v(input logic l);
		int n;
		for (n = 0; data_valid_o !== l && n < T_LIMIT; n++) @(posedge clk_i);
		@(negedge clk_i);
		if (data_valid_o !== l) chk({23'h0, data_valid_o}, {23'h0, l});
	endtask
	task push(input logic [DATA_W-1:0] d);
		meas_data_i = d;
		meas_valid_i = 1;
		@(negedge clk_i);
		meas_valid_i = 0;
	endtask
	task wrap_up;
		if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task t_fill;
		// Hold synchroniser starts cleared; let it settle before filling
		repeat (4) @(negedge clk_i);
		for (int i = 0; i < 8; i++) push(24'h12_3450 + i);
		chk({23'h0, meas_ready_o}, 24'h00_0000);
		hold_i = 0;
		repeat (12) @(negedge clk_i);
		chk(bcd_data_o, DATA_IDLE);
	endtask
	task t_single;
		go = 1;
		repeat (10) @(negedge clk_i);
		go = 0;
		wait_v(1);
		chk(bcd_data_o, 24'h12_3457);
		wait_v(0);
		repeat (T_GAP) @(negedge clk_i);
		chk(bcd_data_o, DATA_IDLE);
		chk(got, 24'h12_3457);
	endtask
	task t_cont;
		go = 1;
		wait_v(1);
		push(24'h65_4321);
		repeat (T_PERIOD - 10) @(negedge clk_i);
		hold_i = 1;
		repeat (20) @(negedge clk_i);
		chk(bcd_data_o === 24'h12_3457 ? 24'h65_4321 : bcd_data_o, 24'h65_4321);
		hold_i = 0;
		repeat (T_PERIOD) @(negedge clk_i);
		chk(bcd_data_o, 24'h65_4321);
		go = 0;
		wait_v(0);
		repeat (T_RELEASE + 10) @(negedge clk_i);
		chk(bcd_data_o, DATA_IDLE);
	endtask
	initial begin
		#800_000;
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (12) @(negedge clk_i);
		rst_i = 0;
		t_fill();
		t_single();
		t_cont();
		wrap_up();
	end
endmodule
